// ==== cptd_pkg.sv ====
// Shared constants and carrier types for the instruction decode and timing core.
// Assumes a synchronous program memory and data register file on core_clk.
// Functional notes
// [RULE1] Each fetched word is one 14-bit instruction carrying opcode and operands.
// [RULE2] Direct and accumulator-based subroutine entry both take two instruction cycles.
// [RULE3] Plain return, return with constant and interrupt exit take two cycles.
// [RULE4] Jumps and taken skips take two cycles; everything else takes one. Here an indirect access to program memory also adds a refetch cycle.
// [RULE5] Indirect access through a pointer aimed at program memory adds one cycle.
// [RULE6] One instruction cycle is exactly four oscillator clocks.
// [RULE7] Writes to a named file register are read, modify, then store.
// [RULE8] The named file register is read even when the instruction only writes it.
// [RULE9] Destination bit 0 stores to the accumulator, 1 back to the file register.
// [RULE10] The file address operand is 7 bits, 0x00 to 0x7F within the bank.
// [RULE11] Bit instructions carry a 3-bit position picking one of eight bits.
// [RULE12] Don't-care opcode bits are ignored by the decoder.
// [RULE13] Indirect instructions carry one bit choosing pointer 0 or pointer 1.
// [RULE14] Indirect moves carry a pre/post increment/decrement pointer update mode.
// [RULE15] Instructions changing the program counter or passing a test take two cycles.
// [RULE16] The second cycle of a two-cycle instruction executes as a no-operation.
// [RULE17] The accumulator is 8 bits; results commit at the end of the cycle.
package cptd_pkg;
  localparam int INSTR_W = 14;
  localparam int PC_W = 15;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int BANK_W = 5;
  localparam int LATH_W = 7;
  localparam int PTR_W = 16;
  localparam int BUS_ADDR_W = 12;
  localparam int STACK_DEPTH = 16;
  localparam int OSC_PER_INSTR = 4;
  // Clock phase within the instruction cycle at which each step happens.
  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_READ = 2'h1;
  localparam logic [1:0] PH_OPND = 2'h2;
  localparam logic [1:0] PH_COMMIT = 2'h3;
  // Instruction classes held in the two top opcode bits.
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  // Core registers overlaid on the file address space.
  localparam logic [6:0] ADDR_PTR0_LO = 7'h04;
  localparam logic [6:0] ADDR_PTR0_HI = 7'h05;
  localparam logic [6:0] ADDR_PTR1_LO = 7'h06;
  localparam logic [6:0] ADDR_PTR1_HI = 7'h07;
  localparam logic [6:0] ADDR_BANK = 7'h08;
  localparam logic [INSTR_W-1:0] INSTR_NOP = 14'h0000;

  typedef enum logic {STG_RUN, STG_REFETCH} cptd_stage_t;

  typedef struct packed {
    logic [BUS_ADDR_W-1:0] addr;
    logic rdStb;
    logic wrStb;
    logic [DATA_W-1:0] wrData;
  } cptd_fr_req_t;

  typedef struct packed {
    logic [1:0] phase;
    cptd_stage_t stage;
    logic skipPend;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] pmAddr;
    logic [INSTR_W-1:0] ir;
    logic [DATA_W-1:0] acc;
    logic zf;
    logic cf;
    logic [BANK_W-1:0] bank;
    logic [LATH_W-1:0] pcLatch;
    logic [PTR_W-1:0] ptr0;
    logic [PTR_W-1:0] ptr1;
    logic [DATA_W-1:0] opnd;
    cptd_fr_req_t fr;
  } cptd_core_t;

  localparam cptd_core_t CORE_RST = '0;
endpackage

// ==== cptd_stack.sv ====
// Return address stack with the top of stack held in a register.
// Assumes push and pop are never asserted together; overflow wraps silently.
`timescale 1ns/1ns
module cptd_stack #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rstN,
  input wire logic ce,
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] top
);
  localparam int SP_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [SP_W-1:0] sp_r;

  // The array holds everything below the top entry, so a pop reads one word back.
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      sp_r <= '0;
      top <= '0;
    end else if (ce) begin
      if (push) begin
        mem[sp_r] <= top;
        top <= din;
        sp_r <= sp_r + 1'b1;
      end else if (pop) begin
        top <= mem[sp_r - 1'b1];
        sp_r <= sp_r - 1'b1;
      end
    end
  end
endmodule

// ==== cptd_core.sv ====
// Instruction decode and timing core: fetch, decode, operand read and commit.
// Assumes program memory and file registers answer one clock after the address.
`timescale 1ns/1ns
module cptd_core (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [cptd_pkg::INSTR_W-1:0] pmData,
  output logic [cptd_pkg::PC_W-1:0] pmAddr,
  input wire logic [cptd_pkg::DATA_W-1:0] frRdData,
  output cptd_pkg::cptd_fr_req_t frReq,
  output logic [cptd_pkg::DATA_W-1:0] accOut,
  output logic [1:0] instrPhase
);
  import cptd_pkg::*;

  logic rstMeta_r;
  logic rstN;
  cptd_core_t s_r;
  cptd_core_t s_nxt;
  logic [PC_W-1:0] stackTop;
  logic stkPush;
  logic stkPop;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_r <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN <= rstMeta_r;
    end
  end

  cptd_stack #(.WIDTH(PC_W), .DEPTH(STACK_DEPTH)) u_stack (
    .core_clk(core_clk),
    .rstN(rstN),
    .ce(ce),
    .push(stkPush),
    .pop(stkPop),
    .din(s_r.pc),
    .top(stackTop)
  );

  always_comb begin
    logic [1:0] cls;
    logic [3:0] op;
    logic dBit;
    logic [FADDR_W-1:0] fAd;
    logic [2:0] bSel;
    logic [DATA_W-1:0] k8;
    logic fileOp, indirect_data_port, ptrOp, ptrWr, ptrN, pmInd, exec;
    logic [1:0] mm;
    logic [PTR_W-1:0] ptrCur, ptrStep, effPtr;
    logic [DATA_W-1:0] vLive, v;
    logic [8:0] r;
    logic toW, toF, zEn, cEn, skip, jump, push, pop;
    logic [PC_W-1:0] tgt;
    s_nxt = s_r;
    cls = s_r.ir[13:12];
    op = s_r.ir[11:8];
    dBit = s_r.ir[7];
    fAd = s_r.ir[6:0]; // [RULE10]
    bSel = s_r.ir[9:7]; // [RULE11]
    k8 = s_r.ir[7:0];
    exec = (s_r.stage == STG_RUN);
    // Any instruction naming a file register, including clear and plain store.
    if (cls == CLS_BYTE) begin
      fileOp = (op == 4'h0) ? dBit : !(op == 4'h1 && !dBit); // [RULE12]
    end else if (cls == CLS_BIT) begin
      fileOp = 1'b1;
    end else begin
      fileOp = (cls == CLS_LIT) && (op inside {4'h5, 4'h6, 4'h7, 4'hB, 4'hD});
    end
    ptrOp = (cls == CLS_BYTE) && (op == 4'h0) && !dBit && (fAd[6:4] == 3'h1);
    ptrWr = ptrOp && fAd[3];
    indirect_data_port = fileOp && (fAd[6:1] == 6'h00);
    ptrN = ptrOp ? s_r.ir[2] : fAd[0]; // [RULE13]
    mm = s_r.ir[1:0];
    ptrCur = ptrN ? s_r.ptr1 : s_r.ptr0;
    ptrStep = mm[0] ? ptrCur - 1'b1 : ptrCur + 1'b1; // [RULE14]
    effPtr = (ptrOp && !mm[1]) ? ptrStep : ptrCur; // [RULE14]
    pmInd = (indirect_data_port || ptrOp) && effPtr[PTR_W-1];
    // Core registers answer reads in place of the external file.
    if (pmInd) begin
      vLive = pmData[DATA_W-1:0];
    end else if (fileOp && !indirect_data_port && fAd == ADDR_PTR0_LO) begin
      vLive = s_r.ptr0[7:0];
    end else if (fileOp && !indirect_data_port && fAd == ADDR_PTR0_HI) begin
      vLive = s_r.ptr0[15:8];
    end else if (fileOp && !indirect_data_port && fAd == ADDR_PTR1_LO) begin
      vLive = s_r.ptr1[7:0];
    end else if (fileOp && !indirect_data_port && fAd == ADDR_PTR1_HI) begin
      vLive = s_r.ptr1[15:8];
    end else if (fileOp && !indirect_data_port && fAd == ADDR_BANK) begin
      vLive = {3'h0, s_r.bank};
    end else begin
      vLive = frRdData;
    end
    v = (s_r.phase == PH_OPND) ? vLive : s_r.opnd;
    r = 9'h000;
    toW = 1'b0;
    toF = 1'b0;
    zEn = 1'b0;
    cEn = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    tgt = s_r.pc;
    unique case (cls)
      CLS_BYTE: begin
        toF = dBit; // [RULE9]
        toW = !dBit; // [RULE9]
        zEn = 1'b1;
        unique case (op)
          4'h0: begin
            zEn = 1'b0;
            toW = 1'b0;
            r = {1'b0, s_r.acc};
            if (ptrOp) begin
              toF = ptrWr;
              toW = !ptrWr;
              zEn = !ptrWr;
              r = ptrWr ? {1'b0, s_r.acc} : {1'b0, v};
            end else if (!dBit && (fAd == 7'h08 || fAd == 7'h09)) begin
              jump = 1'b1; // [RULE3]
              pop = 1'b1;
              tgt = stackTop;
            end else if (!dBit && fAd == 7'h0A) begin
              jump = 1'b1; // [RULE2]
              push = 1'b1;
              tgt = {s_r.pcLatch, s_r.acc};
            end else if (!dBit && fAd == 7'h0B) begin
              jump = 1'b1; // [RULE4]
              tgt = s_r.pc + {7'h00, s_r.acc};
            end
          end
          4'h1: r = 9'h000;
          4'h2: begin
            r = {1'b0, v} + {1'b0, ~s_r.acc} + 9'h001;
            cEn = 1'b1;
          end
          4'h3: r = {1'b0, v - 8'h01};
          4'h4: r = {1'b0, v | s_r.acc};
          4'h5: r = {1'b0, v & s_r.acc};
          4'h6: r = {1'b0, v ^ s_r.acc};
          4'h7: begin
            r = {1'b0, v} + {1'b0, s_r.acc};
            cEn = 1'b1;
          end
          4'h8: r = {1'b0, v};
          4'h9: r = {1'b0, ~v};
          4'hA: r = {1'b0, v + 8'h01};
          4'hB: begin
            r = {1'b0, v - 8'h01};
            zEn = 1'b0;
            skip = (r[7:0] == 8'h00); // [RULE4]
          end
          4'hC: begin
            r = {v[0], s_r.cf, v[7:1]};
            zEn = 1'b0;
            cEn = 1'b1;
          end
          4'hD: begin
            r = {v, s_r.cf};
            zEn = 1'b0;
            cEn = 1'b1;
          end
          4'hE: begin
            r = {1'b0, v[3:0], v[7:4]};
            zEn = 1'b0;
          end
          4'hF: begin
            r = {1'b0, v + 8'h01};
            zEn = 1'b0;
            skip = (r[7:0] == 8'h00); // [RULE4]
          end
        endcase
      end
      CLS_BIT: begin
        r = {1'b0, v};
        toF = !op[3];
        r[bSel] = op[2]; // [RULE11]
        if (op[3]) begin
          r = {1'b0, v};
          skip = (v[bSel] == op[2]); // [RULE4]
        end
      end
      CLS_JUMP: begin
        jump = 1'b1; // [RULE2] [RULE4]
        push = !s_r.ir[11];
        tgt = {s_r.pcLatch[6:3], s_r.ir[10:0]};
      end
      CLS_LIT: begin
        toW = 1'b1;
        zEn = 1'b1;
        unique case (op)
          4'h0: begin
            r = {1'b0, k8};
            zEn = 1'b0;
          end
          4'h2, 4'h3: begin
            toW = 1'b0;
            zEn = 1'b0;
            jump = 1'b1; // [RULE4]
            tgt = s_r.pc + {{6{s_r.ir[8]}}, s_r.ir[8:0]};
          end
          4'h4: begin
            r = {1'b0, k8};
            zEn = 1'b0;
            jump = 1'b1; // [RULE3]
            pop = 1'b1;
            tgt = stackTop;
          end
          4'h5: r = {v, 1'b0};
          4'h6: r = {v[0], 1'b0, v[7:1]};
          4'h7: r = {v[0], v[7], v[7:1]};
          4'h8: r = {1'b0, k8 | s_r.acc};
          4'h9: r = {1'b0, k8 & s_r.acc};
          4'hA: r = {1'b0, k8 ^ s_r.acc};
          4'hB: r = {1'b0, v} + {1'b0, ~s_r.acc} + {8'h00, s_r.cf};
          4'hC: r = {1'b0, k8} + {1'b0, ~s_r.acc} + 9'h001;
          4'hD: r = {1'b0, v} + {1'b0, s_r.acc} + {8'h00, s_r.cf};
          4'hE: r = {1'b0, k8} + {1'b0, s_r.acc};
          default: begin
            toW = 1'b0;
            zEn = 1'b0;
          end
        endcase
        cEn = op inside {4'h5, 4'h6, 4'h7, 4'hB, 4'hC, 4'hD, 4'hE};
        if (fileOp) begin
          toF = dBit; // [RULE9]
          toW = !dBit; // [RULE9]
        end
      end
    endcase
    stkPush = exec && (s_r.phase == PH_COMMIT) && push && !pmInd;
    stkPop = exec && (s_r.phase == PH_COMMIT) && pop;

    // Four clock phases make one instruction cycle.
    s_nxt.phase = s_r.phase + 2'h1; // [RULE6]
    unique case (s_r.phase)
      PH_ADDR: begin
        if (exec) begin
          s_nxt.fr.addr = (indirect_data_port || ptrOp) ? effPtr[BUS_ADDR_W-1:0] : {s_r.bank, fAd};
          // Every named register is read first, even by pure stores.
          s_nxt.fr.rdStb = (fileOp || ptrOp) && !pmInd; // [RULE7] [RULE8]
          if (pmInd) begin
            s_nxt.pmAddr = effPtr[PC_W-1:0]; // [RULE5]
          end
        end
      end
      PH_READ: s_nxt.fr.rdStb = 1'b0;
      PH_OPND: begin
        if (exec) begin
          s_nxt.opnd = vLive;
          s_nxt.fr.wrData = r[7:0]; // [RULE7]
          // Program memory is read only through the pointer.
          s_nxt.fr.wrStb = toF && !pmInd; // [RULE9]
        end
      end
      PH_COMMIT: begin
        s_nxt.fr.wrStb = 1'b0;
        if (!exec) begin
          // Refetch slot after a program memory operand; a pending skip drops the word.
          s_nxt.ir = s_r.skipPend ? INSTR_NOP : pmData; // [RULE5] [RULE16]
          s_nxt.pc = s_r.pc + 1'b1;
          s_nxt.pmAddr = s_r.pc + 1'b1;
          s_nxt.stage = STG_RUN;
          s_nxt.skipPend = 1'b0;
        end else begin
          if (toW) begin
            s_nxt.acc = r[7:0]; // [RULE17] [RULE9]
          end
          if (zEn) begin
            s_nxt.zf = (r[7:0] == 8'h00);
          end
          if (cEn) begin
            s_nxt.cf = r[8];
          end
          if (cls == CLS_BYTE && op == 4'h0 && !dBit && fAd[6:5] == 2'h1) begin
            s_nxt.bank = fAd[4:0];
          end
          if (cls == CLS_LIT && op == 4'h1 && dBit) begin
            s_nxt.pcLatch = fAd;
          end
          if (toF && fileOp && !indirect_data_port) begin
            if (fAd == ADDR_PTR0_LO) s_nxt.ptr0[7:0] = r[7:0];
            if (fAd == ADDR_PTR0_HI) s_nxt.ptr0[15:8] = r[7:0];
            if (fAd == ADDR_PTR1_LO) s_nxt.ptr1[7:0] = r[7:0];
            if (fAd == ADDR_PTR1_HI) s_nxt.ptr1[15:8] = r[7:0];
            if (fAd == ADDR_BANK) s_nxt.bank = r[BANK_W-1:0];
          end
          if (ptrOp) begin
            if (ptrN) s_nxt.ptr1 = ptrStep; // [RULE14]
            else s_nxt.ptr0 = ptrStep; // [RULE14]
          end
          if (pmInd) begin
            // The fetch was displaced by the operand read, so one more cycle refetches.
            s_nxt.stage = STG_REFETCH; // [RULE5]
            s_nxt.skipPend = skip;
            s_nxt.pmAddr = s_r.pc;
          end else if (jump) begin
            s_nxt.ir = INSTR_NOP; // [RULE15] [RULE16]
            s_nxt.pc = tgt;
            s_nxt.pmAddr = tgt;
          end else if (skip) begin
            s_nxt.ir = INSTR_NOP; // [RULE4] [RULE15] [RULE16]
            s_nxt.pc = s_r.pc + 1'b1;
            s_nxt.pmAddr = s_r.pc + 1'b1;
          end else begin
            s_nxt.ir = pmData; // [RULE1]
            s_nxt.pc = s_r.pc + 1'b1;
            s_nxt.pmAddr = s_r.pc + 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      s_r <= CORE_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign pmAddr = s_r.pmAddr;
  assign frReq = s_r.fr;
  assign accOut = s_r.acc;
  assign instrPhase = s_r.phase;
endmodule

// ==== cptd_core_assertions.sv ====
// Concurrent checks on the ports of the instruction decode and timing core.
// Assumes it is bound to cptd_core and sees nothing but that module's ports.
`timescale 1ns/1ns
module cptd_core_assertions (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [cptd_pkg::INSTR_W-1:0] pmData,
  input wire logic [cptd_pkg::PC_W-1:0] pmAddr,
  input wire logic [cptd_pkg::DATA_W-1:0] frRdData,
  input wire cptd_pkg::cptd_fr_req_t frReq,
  input wire logic [cptd_pkg::DATA_W-1:0] accOut,
  input wire logic [1:0] instrPhase
);
  import cptd_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Phase 0 is excluded because the synchroniser holds it for two edges after reset.
  property p_phase_step;
    ce && instrPhase != 2'h0 |=> instrPhase == 2'($past(instrPhase) + 2'h1);
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase did not advance");
  property p_phase_leave;
    ce && instrPhase == 2'h0 && $past(instrPhase) == 2'h3 |=> instrPhase == 2'h1;
  endproperty
  a_phase_leave: assert property (p_phase_leave) else $error("phase stuck at zero");
  property p_rd_once;
    frReq.rdStb |-> instrPhase == 2'h1 ##1 !frReq.rdStb [*3];
  endproperty
  a_rd_once: assert property (p_rd_once) else $error("read strobe misplaced");
  property p_wr_after_rd;
    frReq.wrStb |-> $past(frReq.rdStb, 2) && frReq.addr == $past(frReq.addr, 2);
  endproperty
  a_wr_after_rd: assert property (p_wr_after_rd) else $error("write without read");
  property p_wr_phase;
    frReq.wrStb |-> instrPhase == 2'h3 ##1 !frReq.wrStb [*3];
  endproperty
  a_wr_phase: assert property (p_wr_phase) else $error("write strobe misplaced");
  property p_pm_step;
    $changed(pmAddr) |-> $past(instrPhase) == 2'h3 || $past(instrPhase) == 2'h0;
  endproperty
  a_pm_step: assert property (p_pm_step) else $error("fetch address moved mid cycle");
  property p_acc_commit;
    $changed(accOut) |-> $past(instrPhase) == 2'h3;
  endproperty
  a_acc_commit: assert property (p_acc_commit) else $error("accumulator moved early");
  property p_addr_hold;
    $changed(frReq.addr) |-> $past(instrPhase) == 2'h0;
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("file address moved");
endmodule

bind cptd_core cptd_core_assertions chk_u (.core_clk(core_clk), .resetn(resetn), .ce(ce),
  .pmData(pmData), .pmAddr(pmAddr), .frRdData(frRdData), .frReq(frReq), .accOut(accOut),
  .instrPhase(instrPhase));

// ==== cptd_mem_model.sv ====
// Program memory and file register model facing the decode core.
// Assumes one clock of read latency and preload by the bench through hierarchy.
`timescale 1ns/1ns
module cptd_mem_model (
  input wire logic core_clk,
  input wire logic [cptd_pkg::PC_W-1:0] pmAddr,
  output logic [cptd_pkg::INSTR_W-1:0] pmData,
  input wire cptd_pkg::cptd_fr_req_t frReq,
  output logic [cptd_pkg::DATA_W-1:0] frRdData
);
  import cptd_pkg::*;
  logic [INSTR_W-1:0] pm [64];
  logic [DATA_W-1:0] fr [4096];
  initial begin
    pmData = '0;
    frRdData = '0;
  end
  always @(posedge core_clk) begin
    pmData <= (pmAddr < 15'h0040) ? pm[pmAddr[5:0]] : INSTR_NOP;
    // Outside a read the lines flip, so a stale byte never passes for an answer.
    frRdData <= frReq.rdStb ? fr[frReq.addr] : ~frRdData;
    if (frReq.wrStb) begin
      fr[frReq.addr] <= frReq.wrData;
    end
  end
endmodule

// ==== cpu_instruction_timing_decode_tb.sv ====
// Self-checking bench for the decode core running short programs from the memory model.
// Assumes the package, core, checker and memory model are compiled before it.
`timescale 1ns/1ns
module cpu_instruction_timing_decode_tb;
  import cptd_pkg::*;
  typedef struct {
    logic [13:0] w0, w1, w4;
    logic [7:0] acc;
    int last;
    logic [11:0] fa;
    logic [7:0] fv;
  } cptd_row_t;
  logic core_clk;
  logic resetn;
  logic ce;
  logic [PC_W-1:0] pmAddr;
  logic [INSTR_W-1:0] pmData;
  logic [DATA_W-1:0] frRdData;
  logic [DATA_W-1:0] accOut;
  logic [DATA_W-1:0] prevAcc;
  logic [1:0] instrPhase;
  cptd_fr_req_t frReq;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  int lastChg = 0;
  logic [7:0] hist [$];
  logic [7:0] expHist [9] = '{8'h80, 8'h10, 8'hA5, 8'hA6, 8'h20, 8'h80, 8'hFF, 8'h80, 8'h00};
  logic [13:0] ptrWords [14] = '{14'h3080, 14'h0085, 14'h3010, 14'h0084, 14'h0800, 14'h3E01,
    14'h3020, 14'h0086, 14'h0016, 14'h0014, 14'h0017, 14'h0015, 14'h0103, 14'h001E};
  // Each program: w0, w1 under test, fixed adds of 0x22 and 0x40, then w4.
  cptd_row_t rows [15] = '{
    '{14'h3011, 14'h0000, 14'h0000, 8'h73, 5, 12'h023, 8'h05},
    '{14'h3011, 14'h2803, 14'h0000, 8'h51, 5, 12'h023, 8'h05},
    '{14'h3011, 14'h3201, 14'h0000, 8'h51, 5, 12'h023, 8'h05},
    '{14'h3001, 14'h000B, 14'h0000, 8'h41, 5, 12'h023, 8'h05},
    '{14'h3011, 14'h2003, 14'h0008, 8'hB3, 9, 12'h023, 8'h05},
    '{14'h3003, 14'h000A, 14'h0008, 8'hA5, 9, 12'h023, 8'h05},
    '{14'h3011, 14'h2003, 14'h3477, 8'h77, 10, 12'h023, 8'h05},
    '{14'h3011, 14'h2003, 14'h0009, 8'hB3, 9, 12'h023, 8'h05},
    '{14'h3011, 14'h1FA0, 14'h0000, 8'h51, 5, 12'h023, 8'h05},
    '{14'h3011, 14'h1BA0, 14'h0000, 8'h73, 5, 12'h023, 8'h05},
    '{14'h3011, 14'h0B21, 14'h0000, 8'h40, 5, 12'h021, 8'h01},
    '{14'h3011, 14'h0F22, 14'h0000, 8'h40, 5, 12'h022, 8'hFF},
    '{14'h3011, 14'h07A3, 14'h0000, 8'h73, 5, 12'h023, 8'h16},
    '{14'h3011, 14'h0723, 14'h0000, 8'h78, 5, 12'h023, 8'h05},
    '{14'h3011, 14'h00FF, 14'h0000, 8'h73, 5, 12'h07F, 8'h11}
  };
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  cptd_core dut_u (.core_clk(core_clk), .resetn(resetn), .ce(ce), .pmData(pmData),
    .pmAddr(pmAddr), .frRdData(frRdData), .frReq(frReq), .accOut(accOut),
    .instrPhase(instrPhase));
  cptd_mem_model mem_u (.core_clk(core_clk), .pmAddr(pmAddr), .pmData(pmData), .frReq(frReq),
    .frRdData(frRdData));
  always @(posedge core_clk) begin
    if (resetn !== 1'b1) begin
      cyc = 0;
    end else if (instrPhase === 2'h3) begin
      cyc = cyc + 1;
    end
  end
  // Sampled on the falling edge so the commit edge's updates have landed.
  always @(negedge core_clk) begin
    if (resetn === 1'b1 && accOut !== prevAcc) begin
      hist.push_back(accOut);
      lastChg = cyc;
    end
    prevAcc = accOut;
  end
  task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkCount(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      miscompares++;
      $display("ERROR at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Memory is loaded while reset is held, so the core never fetches a half-built program.
  task automatic runProg(input int n, input logic [13:0] w0, w1, w4, input logic usePtr);
    int k;
    resetn = 1'b0;
    @(negedge core_clk);
    foreach (mem_u.pm[i]) mem_u.pm[i] = INSTR_NOP;
    mem_u.pm[0] = w0;
    mem_u.pm[1] = w1;
    mem_u.pm[2] = 14'h3E22;
    mem_u.pm[3] = 14'h3E40;
    mem_u.pm[4] = w4;
    if (usePtr) begin
      foreach (ptrWords[i]) mem_u.pm[i] = ptrWords[i];
      mem_u.pm[16] = 14'h3AA5;
    end
    mem_u.fr[12'h020] = 8'h80;
    mem_u.fr[12'h021] = 8'h01;
    mem_u.fr[12'h022] = 8'hFF;
    mem_u.fr[12'h023] = 8'h05;
    mem_u.fr[12'h07F] = 8'h00;
    repeat (7) @(negedge core_clk);
    chkVal({8'h00, accOut}, 16'h0000);
    chkVal({1'b0, pmAddr}, 16'h0000);
    chkVal({12'h000, instrPhase, frReq.rdStb, frReq.wrStb}, 16'h0000);
    hist.delete();
    resetn = 1'b1;
    for (k = 0; k < 4 * n + 40 && cyc < n; k++) @(negedge core_clk);
    if (cyc < n) begin
      miscompares++;
      results();
    end
    repeat (2) @(negedge core_clk);
  endtask
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    prevAcc = '0;
    foreach (rows[i]) begin
      runProg(10, rows[i].w0, rows[i].w1, rows[i].w4, 1'b0);
      chkVal({8'h00, accOut}, {8'h00, rows[i].acc});
      chkCount(lastChg, rows[i].last);
      chkVal({8'h00, mem_u.fr[rows[i].fa]}, {8'h00, rows[i].fv});
      $display("row %0d done", i);
    end
    runProg(16, 14'h0000, 14'h0000, 14'h0000, 1'b1);
    chkCount(hist.size(), 9);
    foreach (expHist[i]) chkVal({8'h00, hist[i]}, {8'h00, expHist[i]});
    chkCount(lastChg, 15);
    chkVal({8'h00, mem_u.fr[12'h020]}, 16'h0000);
    $display("pointer test done");
    results();
  end
endmodule
